// ### rtl/cmp_ctrl_pkg.sv
/*
 * constants for the comparator mode and input-select control block.
 * assumes an 8-bit special-function register bus clocked by the system clock.
 */
package cmp_ctrl_pkg;
	localparam logic [7:0] MODE_CTRL_ADDR   = 8'h9d;
	localparam logic [7:0] INPUT_SEL_ADDR   = 8'h9f;
	localparam int         RISE_IE_BIT      = 5;
	localparam int         FALL_IE_BIT      = 4;
	localparam logic [1:0] MODE_RESET       = 2'h2;
	localparam logic [2:0] POS_SEL_RESET    = 3'h0;
	localparam logic [2:0] NEG_SEL_RESET    = 3'h0;
	localparam int         POS_SEL_LSB      = 4;
	localparam int         NEG_SEL_LSB      = 0;
	localparam int         MODE_LSB         = 0;
	localparam logic       IE_RESET         = 1'b0;
	localparam logic       LEVEL_RESET      = 1'b0;
	localparam logic [7:0] RDATA_RESET      = 8'h00;
	localparam int         SYNC_STAGES      = 2;
	typedef enum logic [1:0] {
		MODE_FAST,
		MODE_MID,
		MODE_SLOW
	} resp_mode_e;
endpackage : cmp_ctrl_pkg

// ### rtl/cmp_sync.sv
/*
 * two-flop synchroniser for the asynchronous comparator output.
 * assumes a single clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module cmp_sync (
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_q   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : cmp_sync
`default_nettype wire

// ### rtl/cmp_ctrl.sv
/*
 * comparator control: mode register, input-select register, edge interrupts.
 * assumes a single-cycle sfr bus with write strobe and read strobe on core_clk_in,
 * and an analog comparator output that is asynchronous to the clock.
 */
// Notes on behaviour
// R1: bit 5 of the mode register enables an interrupt on a rising comparator edge.
// R2: bit 4 of the mode register enables an interrupt on a falling comparator edge.
// R3: bits 1:0 pick fast (00), middle (01) or slow low-power (10, 11) response mode.
// R4: bits 7:6 and 3:2 of the mode register read as zero and ignore writes.
// R5: a three-bit field routes the chosen pin to the comparator positive input.
// R6: a three-bit field routes the chosen pin to the comparator negative input.
// R7: software should set each selected pin as an analog input.
// R8: software should have the crossbar skip each selected pin.
// R9: reset clears both edge enables and sets the mode field to 10.
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl
	import cmp_ctrl_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	output var  logic [7:0] sfr_rdata_out,
	input  wire logic       cmp_async_in,
	output var  logic       cmp_level_out,
	output var  logic       rise_irq_out,
	output var  logic       fall_irq_out,
	output var  logic [1:0] resp_mode_out,
	output var  logic [2:0] pos_sel_out,
	output var  logic [2:0] neg_sel_out
);
	logic       rise_ie_q;
	logic       fall_ie_q;
	logic [1:0] mode_q;
	logic [2:0] pos_sel_q;
	logic [2:0] neg_sel_q;
	logic       cmp_synced;
	logic       cmp_prev_q;
	logic       mode_wr;
	logic       sel_wr;
	logic       rise_seen;
	logic       fall_seen;
	logic [7:0] rdata_d;
	resp_mode_e mode_dec;

	// software view of the mode register
	function automatic logic [7:0] mode_image(input logic r, input logic f,
		input logic [1:0] m);
		mode_image = {2'h0, r, f, 2'h0, m}; // [R4]
	endfunction : mode_image

	function automatic logic [7:0] sel_image(input logic [2:0] p, input logic [2:0] n);
		sel_image = {1'b0, p, 1'b0, n};
	endfunction : sel_image

	// both register writes go through the same decode; reads use a case on the address
	function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] target);
		reg_hit = strobe && (addr == target);
	endfunction : reg_hit

	// 11 folds onto the slowest mode, as 10 does
	function automatic resp_mode_e mode_of(input logic [1:0] code);
		case (code)
			2'h0:    mode_of = MODE_FAST; // [R3]
			2'h1:    mode_of = MODE_MID; // [R3]
			default: mode_of = MODE_SLOW; // [R3]
		endcase
	endfunction : mode_of

	function automatic logic [1:0] mode_code(input resp_mode_e m);
		case (m)
			MODE_FAST: mode_code = 2'h0;
			MODE_MID:  mode_code = 2'h1;
			default:   mode_code = 2'h2;
		endcase
	endfunction : mode_code

	cmp_sync u_sync (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.async_in    (cmp_async_in),
		.sync_out    (cmp_synced)
	);

	assign mode_wr = reg_hit(sfr_wr_in, sfr_addr_in, MODE_CTRL_ADDR);
	assign sel_wr  = reg_hit(sfr_wr_in, sfr_addr_in, INPUT_SEL_ADDR);

	// edges before the enables; both flops reset low, so no edge out of reset
	assign rise_seen = cmp_synced & ~cmp_prev_q;
	assign fall_seen = ~cmp_synced & cmp_prev_q;

	always_comb begin
		mode_dec = mode_of(mode_q);
	end

	// unmapped addresses read zero
	always_comb begin
		case (sfr_addr_in)
			MODE_CTRL_ADDR: rdata_d = mode_image(rise_ie_q, fall_ie_q, mode_q); // [R4]
			INPUT_SEL_ADDR: rdata_d = sel_image(pos_sel_q, neg_sel_q);
			default:        rdata_d = 8'h00;
		endcase
	end

	// enables and mode change only on a write that hits the mode register
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rise_ie_q <= IE_RESET; // [R9]
		end else if (mode_wr) begin
			rise_ie_q <= sfr_wdata_in[RISE_IE_BIT]; // [R1]
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fall_ie_q <= IE_RESET; // [R9]
		end else if (mode_wr) begin
			fall_ie_q <= sfr_wdata_in[FALL_IE_BIT]; // [R2]
		end
	end

	// spare bits 7:6 and 3:2 have no storage at all
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_q <= MODE_RESET; // [R9]
		end else if (mode_wr) begin
			mode_q <= sfr_wdata_in[MODE_LSB +: 2]; // [R3]
		end
	end

	// input-select register sits at an address of our own choosing
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pos_sel_q <= POS_SEL_RESET;
		end else if (sel_wr) begin
			pos_sel_q <= sfr_wdata_in[POS_SEL_LSB +: 3]; // [R5]
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			neg_sel_q <= NEG_SEL_RESET;
		end else if (sel_wr) begin
			neg_sel_q <= sfr_wdata_in[NEG_SEL_LSB +: 3]; // [R6]
		end
	end

	// read data held until the next read strobe
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sfr_rdata_out <= RDATA_RESET;
		end else if (sfr_rd_in) begin
			sfr_rdata_out <= rdata_d;
		end
	end

	// registered so decode glitches never reach the analog side
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			resp_mode_out <= MODE_RESET;
		end else begin
			resp_mode_out <= mode_code(mode_dec); // [R3]
		end
	end

	// pin routing trusts software to have set the pins analog
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pos_sel_out <= POS_SEL_RESET;
		end else begin
			pos_sel_out <= pos_sel_q; // [R5]
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			neg_sel_out <= NEG_SEL_RESET;
		end else begin
			neg_sel_out <= neg_sel_q; // [R6]
		end
	end

	// previous synchronised level for the edge compare
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cmp_prev_q <= LEVEL_RESET;
		end else begin
			cmp_prev_q <= cmp_synced;
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cmp_level_out <= LEVEL_RESET;
		end else begin
			cmp_level_out <= cmp_synced;
		end
	end

	// one-cycle pulses; any sticky flag lives elsewhere
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rise_irq_out <= 1'b0;
		end else begin
			rise_irq_out <= rise_ie_q & rise_seen; // [R1]
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fall_irq_out <= 1'b0;
		end else begin
			fall_irq_out <= fall_ie_q & fall_seen; // [R2]
		end
	end
endmodule : cmp_ctrl
`default_nettype wire

// ### tb/cmp_ctrl_assertions.sv
/* port checks for cmp_ctrl; bound to every instance, one clock domain */
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl_chk import cmp_ctrl_pkg::*; (
	input wire logic       core_clk_in,
	input wire logic       sys_rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       cmp_async_in,
	input wire logic       cmp_level_out,
	input wire logic       rise_irq_out,
	input wire logic       fall_irq_out,
	input wire logic [1:0] resp_mode_out,
	input wire logic [2:0] pos_sel_out,
	input wire logic [2:0] neg_sel_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence wr_mode; sfr_wr_in && sfr_addr_in == MODE_CTRL_ADDR; endsequence
	sequence wr_sel; sfr_wr_in && sfr_addr_in == INPUT_SEL_ADDR; endsequence
	rise_edge_a: assert property (rise_irq_out |-> $rose(cmp_level_out))
		else $error("rise pulse without edge");
	fall_edge_a: assert property (fall_irq_out |-> $fell(cmp_level_out))
		else $error("fall pulse without edge");
	mode_map_a: assert property (wr_mode |-> ##2 resp_mode_out ==
		($past(sfr_wdata_in[1], 2) ? 2'h2 : $past(sfr_wdata_in[1:0], 2)))
		else $error("mode output wrong");
	unused_zero_a: assert property (sfr_rd_in && sfr_addr_in == MODE_CTRL_ADDR
		|=> (sfr_rdata_out & 8'hcc) == 8'h00) else $error("unused bits set");
	pos_sel_a: assert property (wr_sel |-> ##2 pos_sel_out == $past(sfr_wdata_in[6:4], 2))
		else $error("positive select wrong");
	neg_sel_a: assert property (wr_sel |-> ##2 neg_sel_out == $past(sfr_wdata_in[2:0], 2))
		else $error("negative select wrong");
	reset_state_a: assert property ($fell(sys_rst_in) |-> resp_mode_out == 2'h2
		&& pos_sel_out == 3'h0 && neg_sel_out == 3'h0 && !rise_irq_out && !fall_irq_out
		&& !cmp_level_out && sfr_rdata_out == 8'h00) else $error("reset state");
	level_lag_a: assert property ($changed(cmp_level_out)
		|-> cmp_level_out == $past(cmp_async_in, 3)) else $error("level not three edges late");
endmodule : cmp_ctrl_chk
bind cmp_ctrl cmp_ctrl_chk chk (.core_clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wdata_in,
	.sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .cmp_async_in, .cmp_level_out, .rise_irq_out,
	.fall_irq_out, .resp_mode_out, .pos_sel_out, .neg_sel_out);
`default_nettype wire

// ### tb/testbench.sv
/* self-checking bench for cmp_ctrl; needs the package and checker compiled first */
`timescale 1ns/10ps
`default_nettype none
module testbench import cmp_ctrl_pkg::*;;
	logic       clk, rst, wr, rd, rd_p, cmp, rise, fall;
	logic [7:0] addr, wd, rdata, v;
	logic [9:0] q[$];
	int         n_fail, checked;
	cmp_ctrl dut (.core_clk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr), .sfr_wdata_in(wd),
		.sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .cmp_async_in(cmp),
		.cmp_level_out(), .rise_irq_out(rise), .fall_irq_out(fall), .resp_mode_out(),
		.pos_sel_out(), .neg_sel_out());
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [9:0] s, e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic close_out();
		if (n_fail == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		{addr, wd, wr} <= {a, d, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, e);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		q.push_back({2'b00, e});
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	// expectation {rise, fall, 0}; zero means no pulse may appear
	task automatic edge_to(input logic b, input logic [9:0] e);
		@(posedge clk);
		cmp <= b;
		if (e != 0) q.push_back(e);
		repeat (6) @(posedge clk);
	endtask : edge_to
	always @(posedge clk) begin
		if (rd_p || rise || fall)
			chk(rd_p ? {2'b00, rdata} : {rise, fall, 8'h00}, q.size() ? q.pop_front() : 10'h3ff);
		rd_p <= rd;
	end
	initial begin
		{rst, wr, rd, rd_p, cmp, addr, wd} = {5'b10000, 16'h0000};
		void'($urandom(32'h93c3));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(MODE_CTRL_ADDR, 8'h02);
		rd_reg(INPUT_SEL_ADDR, 8'h00);
		rd_reg(8'h10, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom());
			v[1:0] = i[1:0];
			wr_reg(MODE_CTRL_ADDR, v);
			rd_reg(MODE_CTRL_ADDR, v & 8'h33);
			v = 8'($urandom());
			wr_reg(INPUT_SEL_ADDR, v); // pins taken as analog and skipped
			rd_reg(INPUT_SEL_ADDR, v & 8'h77);
		end
		wr_reg(MODE_CTRL_ADDR, 8'h20);
		edge_to(1'b1, 10'h200);
		edge_to(1'b0, 10'h000);
		wr_reg(MODE_CTRL_ADDR, 8'h13);
		edge_to(1'b1, 10'h000);
		edge_to(1'b0, 10'h100);
		for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk);
		if (q.size() > 0) n_fail++;
		close_out();
	end
endmodule : testbench
`default_nettype wire
